// >>> design/vdc_pkg.sv
package vdc_pkg;
  localparam int CLK_NS  = 100;
  localparam int ROW_W   = 9;
  localparam int SD_W    = 4;
  localparam logic [ROW_W-1:0] SER_LAST = 9'h1ff;
  // ==========================================
  // register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_SDATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_MASK_BIT  = 4;
  localparam int ADDR_ROW_LSB   = 0;
  localparam int ADDR_COL_LSB   = 16;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_MODEWR_BIT  = 1;
  localparam int ST_START_BIT   = 2;
  localparam int ST_ERR_BIT     = 3;
  localparam int ST_PTR_LSB     = 16;
  localparam int CFG_AUTO_BIT   = 0;
  localparam int CFG_RASONLY_BIT = 1;
  // ==========================================
  // timing
  localparam int T_SCDT_NS  = 5;
  localparam int T_DTSC_NS  = 10;
  localparam int T_RASSC_NS = 20;
  localparam int T_RAS_NS = 100;
  localparam int T_RP_NS  = 70;
  localparam int T_SCP_NS = 10;
  localparam int T_REF_MS = 8;
  localparam int REF_ROWS = 512;
  function automatic int cyc(input int ns);
    return (ns <= CLK_NS) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc
  localparam logic [3:0] SCDT_CYC = 4'(cyc(T_SCDT_NS));
  localparam logic [3:0] DTSC_CYC = 4'(cyc(T_DTSC_NS));
  localparam logic [3:0] RAS_CYC  = 4'(cyc(T_RAS_NS));
  localparam logic [3:0] RP_CYC   = 4'(cyc(T_RP_NS));
  localparam logic [3:0] SCP_CYC  = 4'(cyc(T_SCP_NS));
  localparam logic [3:0] REC_CYC  = 4'(cyc(T_RASSC_NS > T_RP_NS ? T_RASSC_NS : T_RP_NS));
  localparam logic [3:0] SYNC_CYC = 4'h3;
  localparam int REF_INTERVAL_CYC = (T_REF_MS * 1000000) / (REF_ROWS * CLK_NS);
  // ==========================================
  // types
  typedef enum logic [3:0] {
    OP_NONE, OP_READ_XFER, OP_PSEUDO_XFER, OP_WRITE_XFER, OP_RAS_REFRESH,
    OP_CTR_REFRESH, OP_HIDDEN_REFRESH, OP_SERIAL_READ, OP_SERIAL_WRITE
  } vdc_op_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_ROW, ST_COL, ST_DT_RISE, ST_HID_PRE, ST_HID_RAS,
    ST_RAS_HI, ST_CLK_HI, ST_CLK_LO
  } vdc_state_e;
  typedef struct packed {
    logic             rasN;
    logic             casN;
    logic             weN;
    logic             dtoeN;
    logic             spEnN;
    logic             shClk;
    logic [ROW_W-1:0] addr;
  } vdc_pins_s;
  localparam vdc_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000};
endpackage : vdc_pkg

// >>> design/vdc_host.sv
`timescale 1ns/1ps
module vdc_host
  import vdc_pkg::*;
#(
  parameter int REF_INTERVAL = REF_INTERVAL_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // memory strobes and address
  output logic                   rowStrobeN,
  output logic                   colStrobeN,
  output logic                   writeStrobeN,
  output logic                   transferOutputEnableN,
  output logic                   serialPortEnableN,
  output logic                   serialShiftClock,
  output logic [ROW_W-1:0]       memAddr,
  // serial data pins
  input  wire logic [SD_W-1:0]   serialDataIn,
  output logic [SD_W-1:0]        serialDataOut,
  output logic                   serialDataOe
);
  if (REF_INTERVAL < 2 || REF_INTERVAL > 255) begin : g_chk
    $error("REF_INTERVAL out of range");
  end
  localparam logic [7:0] REF_LOAD = 8'(REF_INTERVAL - 1);

  // ==========================================
  // state
  vdc_state_e       stateReg, stateNext;
  vdc_op_e          opReg, opNext;
  vdc_pins_s        pinsReg, pinsNext;
  logic [3:0]       waitReg, waitNext;
  logic [SD_W-1:0]  sdOutReg, sdOutNext, wrDataReg, wrDataNext, rdDataReg, rdDataNext;
  logic             sdOeReg, sdOeNext, maskReg, maskNext;
  logic [ROW_W-1:0] rowReg, rowNext, colReg, colNext, ptrReg, ptrNext;
  logic [ROW_W-1:0] refRowReg, refRowNext;
  logic             autoReg, autoNext, rasOnlyReg, rasOnlyNext, errReg, errNext;
  logic             modeWrReg, modeWrNext, startReg, startNext;
  logic             lastMsbReg, lastMsbNext, lastValidReg, lastValidNext;
  logic [7:0]       refTimerReg, refTimerNext;
  logic             refDueReg, refDueNext;
  logic             dpValidReg, dpValidNext, dpWriteReg, dpWriteNext;
  logic [7:0]       dpAddrReg, dpAddrNext;
  logic [31:0]      hrdataReg, hrdataNext;
  logic [SD_W-1:0]  sdS1, sdS2, sdS3;

  // ==========================================
  // next-state logic
  always_comb begin
    logic [31:0] rdWord;
    logic        cmdGo, cmdMask, ok, xfer, toRecover;
    vdc_op_e     cmdOp, startOp;
    rdWord = 32'h0000_0000;
    cmdGo = 1'b0;
    cmdMask = 1'b0;
    ok = 1'b0;
    xfer = 1'b0;
    toRecover = 1'b0;
    cmdOp = OP_NONE;
    startOp = OP_NONE;
    stateNext = stateReg;
    opNext = opReg;
    pinsNext = pinsReg;
    waitNext = (waitReg != 4'h0) ? waitReg - 4'h1 : 4'h0;
    sdOutNext = sdOutReg;
    sdOeNext = sdOeReg;
    wrDataNext = wrDataReg;
    rdDataNext = rdDataReg;
    maskNext = maskReg;
    rowNext = rowReg;
    colNext = colReg;
    ptrNext = ptrReg;
    refRowNext = refRowReg;
    autoNext = autoReg;
    rasOnlyNext = rasOnlyReg;
    errNext = errReg;
    modeWrNext = modeWrReg;
    startNext = startReg;
    lastMsbNext = lastMsbReg;
    lastValidNext = lastValidReg;
    refDueNext = refDueReg;
    hrdataNext = hrdataReg;
    // address phase: read data is prepared here so it stands from a flop
    dpValidNext = hsel && htrans[1] && hready;
    dpWriteNext = hwrite;
    dpAddrNext = haddr[7:0];
    case (haddr[7:0])
      OFF_ADDR: begin
        rdWord[ADDR_ROW_LSB +: ROW_W] = rowReg;
        rdWord[ADDR_COL_LSB +: ROW_W] = colReg;
      end
      OFF_SDATA: rdWord[SD_W-1:0] = rdDataReg;
      OFF_STATUS: begin
        rdWord[ST_BUSY_BIT] = (stateReg != ST_IDLE);
        rdWord[ST_MODEWR_BIT] = modeWrReg;
        rdWord[ST_START_BIT] = startReg;
        rdWord[ST_ERR_BIT] = errReg;
        rdWord[ST_PTR_LSB +: ROW_W] = ptrReg;
      end
      OFF_CONFIG: begin
        rdWord[CFG_AUTO_BIT] = autoReg;
        rdWord[CFG_RASONLY_BIT] = rasOnlyReg;
      end
      default: rdWord = 32'h0000_0000;
    endcase
    if (dpValidNext && !hwrite) begin
      hrdataNext = rdWord;
    end
    // data phase writes
    if (dpValidReg && dpWriteReg) begin
      case (dpAddrReg)
        OFF_CTRL: begin
          cmdGo = 1'b1;
          cmdOp = vdc_op_e'(hwdata[CTRL_OP_LSB +: 4]);
          cmdMask = hwdata[CTRL_MASK_BIT];
        end
        OFF_ADDR: begin
          rowNext = hwdata[ADDR_ROW_LSB +: ROW_W];
          colNext = hwdata[ADDR_COL_LSB +: ROW_W];
        end
        OFF_SDATA: wrDataNext = hwdata[SD_W-1:0];
        OFF_STATUS: if (hwdata[ST_ERR_BIT]) errNext = 1'b0;
        OFF_CONFIG: begin
          autoNext = hwdata[CFG_AUTO_BIT];
          rasOnlyNext = hwdata[CFG_RASONLY_BIT];
        end
        default: ;
      endcase
    end
    // refresh pacing, one row per interval
    if (refTimerReg == 8'h00) begin
      refTimerNext = REF_LOAD;
    end else begin
      refTimerNext = refTimerReg - 8'h01;
    end
    // ==========================================
    // sequencer
    if (stateReg == ST_IDLE) begin
      if (cmdGo) begin
        startOp = cmdOp;
      end else if (refDueReg && autoReg) begin
        startOp = rasOnlyReg ? OP_RAS_REFRESH : OP_CTR_REFRESH;
        refDueNext = 1'b0;
      end
      case (startOp)
        OP_SERIAL_READ: ok = startReg && !modeWrReg;
        OP_SERIAL_WRITE: ok = startReg && modeWrReg;
        OP_WRITE_XFER: ok = startReg && (!lastValidReg || rowReg[ROW_W-1] == lastMsbReg);
        OP_READ_XFER, OP_PSEUDO_XFER, OP_RAS_REFRESH,
        OP_CTR_REFRESH, OP_HIDDEN_REFRESH: ok = 1'b1;
        default: ok = 1'b0;
      endcase
      xfer = (startOp == OP_READ_XFER) || (startOp == OP_PSEUDO_XFER)
          || (startOp == OP_WRITE_XFER);
      if (cmdGo && !ok) begin
        errNext = 1'b1;
      end
      if (ok) begin
        opNext = startOp;
        maskNext = cmdMask;
        stateNext = ST_SETUP;
        waitNext = SCDT_CYC;
        pinsNext.addr = (startOp == OP_RAS_REFRESH) ? refRowReg : rowReg;
        pinsNext.casN = (startOp != OP_CTR_REFRESH);
        pinsNext.dtoeN = !xfer;
        pinsNext.weN = !((startOp == OP_PSEUDO_XFER) || (startOp == OP_WRITE_XFER));
        if (startOp == OP_WRITE_XFER) begin
          pinsNext.spEnN = 1'b0;
        end else if (startOp == OP_SERIAL_READ || startOp == OP_SERIAL_WRITE) begin
          pinsNext.spEnN = cmdMask;
        end else begin
          pinsNext.spEnN = 1'b1;
        end
        sdOutNext = wrDataReg;
        sdOeNext = (startOp == OP_SERIAL_WRITE);
      end
    end else begin
      if (cmdGo) begin
        errNext = 1'b1;
      end
      // column address settles a cycle before column strobe falls, never with it
      if (stateReg == ST_ROW && opReg != OP_RAS_REFRESH && opReg != OP_CTR_REFRESH) begin
        pinsNext.addr = colReg;
      end
      if (waitReg == 4'h0) begin
        case (stateReg)
          ST_SETUP: begin
            if (opReg == OP_SERIAL_READ || opReg == OP_SERIAL_WRITE) begin
              stateNext = ST_CLK_HI;
              pinsNext.shClk = 1'b1;
              waitNext = SYNC_CYC;
            end else begin
              stateNext = ST_ROW;
              pinsNext.rasN = 1'b0;
              waitNext = RAS_CYC;
            end
          end
          ST_ROW: begin
            if (opReg == OP_RAS_REFRESH || opReg == OP_CTR_REFRESH) begin
              toRecover = 1'b1;
              if (opReg == OP_RAS_REFRESH) refRowNext = refRowReg + 9'h001;
            end else begin
              stateNext = ST_COL;
              pinsNext.addr = colReg;
              pinsNext.casN = 1'b0;
              if (opReg == OP_HIDDEN_REFRESH) pinsNext.dtoeN = 1'b0;
              waitNext = RAS_CYC;
            end
          end
          ST_COL: begin
            if (opReg == OP_READ_XFER) begin
              stateNext = ST_DT_RISE;
              pinsNext.dtoeN = 1'b1;
              waitNext = DTSC_CYC;
            end else if (opReg == OP_HIDDEN_REFRESH) begin
              stateNext = ST_HID_PRE;
              pinsNext.rasN = 1'b1;
              waitNext = RP_CYC;
            end else begin
              toRecover = 1'b1;
            end
          end
          ST_DT_RISE: toRecover = 1'b1;
          ST_HID_PRE: begin
            stateNext = ST_HID_RAS;
            pinsNext.rasN = 1'b0;
            waitNext = RAS_CYC;
          end
          ST_HID_RAS: toRecover = 1'b1;
          ST_RAS_HI: begin
            stateNext = ST_IDLE;
            if (opReg == OP_READ_XFER) begin
              modeWrNext = 1'b0;
              startNext = 1'b1;
              ptrNext = colReg;
              lastMsbNext = rowReg[ROW_W-1];
              lastValidNext = 1'b1;
            end else if (opReg == OP_PSEUDO_XFER || opReg == OP_WRITE_XFER) begin
              modeWrNext = 1'b1;
              if (opReg == OP_PSEUDO_XFER) startNext = 1'b1;
              ptrNext = colReg;
            end
          end
          ST_CLK_HI: begin
            // a masked read floats the pins, so waiting for them to settle could hang
            if (opReg == OP_SERIAL_WRITE || maskReg || sdS2 == sdS3) begin
              if (opReg == OP_SERIAL_READ && !maskReg) rdDataNext = sdS3;
              stateNext = ST_CLK_LO;
              pinsNext.shClk = 1'b0;
              waitNext = SCP_CYC;
            end
          end
          ST_CLK_LO: begin
            stateNext = ST_IDLE;
            pinsNext.spEnN = 1'b1;
            sdOeNext = 1'b0;
            ptrNext = (ptrReg == SER_LAST) ? 9'h000 : ptrReg + 9'h001;
          end
          default: stateNext = ST_IDLE;
        endcase
      end
    end
    if (toRecover) begin
      stateNext = ST_RAS_HI;
      pinsNext = PINS_IDLE;
      pinsNext.addr = pinsReg.addr;
      waitNext = REC_CYC;
    end
    // set wins over the clear taken by a refresh start
    if (refTimerReg == 8'h00) refDueNext = 1'b1;
  end

  // ==========================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stateReg <= ST_IDLE;
      opReg <= OP_NONE;
      pinsReg <= PINS_IDLE;
      waitReg <= 4'h0;
      sdOutReg <= 4'h0;
      sdOeReg <= 1'b0;
      wrDataReg <= 4'h0;
      rdDataReg <= 4'h0;
      maskReg <= 1'b0;
      rowReg <= 9'h000;
      colReg <= 9'h000;
      ptrReg <= 9'h000;
      refRowReg <= 9'h000;
      autoReg <= 1'b0;
      rasOnlyReg <= 1'b0;
      errReg <= 1'b0;
      modeWrReg <= 1'b0;
      startReg <= 1'b0;
      lastMsbReg <= 1'b0;
      lastValidReg <= 1'b0;
      refTimerReg <= 8'h00;
      refDueReg <= 1'b0;
      dpValidReg <= 1'b0;
      dpWriteReg <= 1'b0;
      dpAddrReg <= 8'h00;
      hrdataReg <= 32'h0000_0000;
    end else begin
      stateReg <= stateNext;
      opReg <= opNext;
      pinsReg <= pinsNext;
      waitReg <= waitNext;
      sdOutReg <= sdOutNext;
      sdOeReg <= sdOeNext;
      wrDataReg <= wrDataNext;
      rdDataReg <= rdDataNext;
      maskReg <= maskNext;
      rowReg <= rowNext;
      colReg <= colNext;
      ptrReg <= ptrNext;
      refRowReg <= refRowNext;
      autoReg <= autoNext;
      rasOnlyReg <= rasOnlyNext;
      errReg <= errNext;
      modeWrReg <= modeWrNext;
      startReg <= startNext;
      lastMsbReg <= lastMsbNext;
      lastValidReg <= lastValidNext;
      refTimerReg <= refTimerNext;
      refDueReg <= refDueNext;
      dpValidReg <= dpValidNext;
      dpWriteReg <= dpWriteNext;
      dpAddrReg <= dpAddrNext;
      hrdataReg <= hrdataNext;
    end
  end

  // serial pins come from the memory's own timing, three stages
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdS1 <= 4'h0;
      sdS2 <= 4'h0;
      sdS3 <= 4'h0;
    end else begin
      sdS1 <= serialDataIn;
      sdS2 <= sdS1;
      sdS3 <= sdS2;
    end
  end

  // ==========================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdataReg;
  assign rowStrobeN = pinsReg.rasN;
  assign colStrobeN = pinsReg.casN;
  assign writeStrobeN = pinsReg.weN;
  assign transferOutputEnableN = pinsReg.dtoeN;
  assign serialPortEnableN = pinsReg.spEnN;
  assign serialShiftClock = pinsReg.shClk;
  assign memAddr = pinsReg.addr;
  assign serialDataOut = sdOutReg;
  assign serialDataOe = sdOeReg;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_xfer_levels: assert property ($fell(pinsReg.rasN) && opReg == OP_READ_XFER
    |-> pinsReg.casN && !pinsReg.dtoeN && pinsReg.weN) else $error("bad read transfer levels");
  a_dt_rise_first: assert property ($rose(pinsReg.rasN) && opReg == OP_READ_XFER
    |-> $past(pinsReg.dtoeN, 2)) else $error("transfer enable did not rise first");
  a_pins_released: assert property (!pinsReg.rasN |-> !sdOeReg)
    else $error("serial data driven during row cycle");
  a_no_clk_ras: assert property (!pinsReg.rasN |-> !pinsReg.shClk)
    else $error("serial clock high while row strobe low");
  a_clk_gap: assert property ($rose(pinsReg.rasN) |-> !pinsReg.shClk [*3])
    else $error("serial clock too soon after row strobe");
  a_write_msb: assert property ($fell(pinsReg.rasN) && opReg == OP_WRITE_XFER
    && lastValidReg |-> pinsReg.addr[ROW_W-1] == lastMsbReg) else $error("row msb mismatch");
  a_serial_start: assert property ($rose(pinsReg.shClk) |-> startReg)
    else $error("serial access before start address");
  a_ptr_wrap: assert property (stateReg == ST_CLK_LO && waitReg == 4'h0
    && ptrReg == SER_LAST |=> ptrReg == 9'h000) else $error("pointer did not wrap");
  a_ref_start: assert property (stateReg == ST_IDLE && refDueReg && autoReg
    && !(dpValidReg && dpWriteReg && dpAddrReg == OFF_CTRL) |=> stateReg == ST_SETUP)
    else $error("refresh not started");
  a_rasonly_levels: assert property ($fell(pinsReg.rasN) && opReg == OP_RAS_REFRESH
    |-> pinsReg.dtoeN && pinsReg.casN) else $error("row-only refresh levels");
  a_ctr_order: assert property ($fell(pinsReg.rasN) && (opReg == OP_CTR_REFRESH
    || stateReg == ST_HID_RAS) |-> !pinsReg.casN) else $error("column strobe not low first");
  c_read_xfer: cover property (stateReg == ST_DT_RISE);
  c_hidden: cover property (stateReg == ST_HID_RAS);
  c_serial_wr: cover property ($rose(pinsReg.shClk) && sdOeReg);
  c_wrap: cover property (stateReg == ST_CLK_LO && ptrReg == SER_LAST);
endmodule : vdc_host

// >>> bench/vdc_vram_model.sv
`timescale 1ns/1ps
module vdc_vram_model
  import vdc_pkg::*;
(
  // strobes and address
  input  wire logic             rowStrobeN,
  input  wire logic             colStrobeN,
  input  wire logic             writeStrobeN,
  input  wire logic             transferOutputEnableN,
  input  wire logic             serialPortEnableN,
  input  wire logic             serialShiftClock,
  input  wire logic [ROW_W-1:0] memAddr,
  // serial pins
  input  wire logic [SD_W-1:0]  sdIn,
  input  wire logic             ctlOe,
  output logic [SD_W-1:0]       devData,
  output logic                  devOe
);
  // ==========================================
  // storage
  logic [3:0] ram [512][512];
  logic [3:0] serReg [512]; // static, never refreshed
  logic [8:0] row, ptr, startCol, lastRd;
  logic [2:0] kind;
  logic       rdMode, started, dtRose, hasRd, haveOut;
  int         ctrCount, viol;
  realtime    tSc, tRas;
  initial begin
    for (int r = 0; r < 512; r++)
      for (int c = 0; c < 512; c++) ram[r][c] = 4'(r ^ (c >> 2));
    {rdMode, started, hasRd, haveOut, kind, ptr, devData} = '0;
    ctrCount = 0;
    viol = 0;
    tSc = -1.0e9;
    tRas = -1.0e9;
  end
  // outputs only in read mode with serial enable low
  assign devOe = rdMode & ~serialPortEnableN & haveOut;
  // ==========================================
  // cycle decode at row strobe fall
  always @(negedge rowStrobeN) begin
    row = memAddr;
    dtRose = 1'b0;
    if (!colStrobeN) begin
      kind = 3'd4;
      ctrCount++;
    end else if (transferOutputEnableN) kind = 3'd0;
    else if (writeStrobeN) kind = 3'd1;
    else if (serialPortEnableN) kind = 3'd2;
    else kind = 3'd3;
    if (kind == 3'd3 && hasRd && lastRd[8] !== memAddr[8]) viol++;
  end
  always @(negedge colStrobeN) if (!rowStrobeN && kind != 3'd0 && kind != 3'd4) begin
    startCol = memAddr;
    if (kind != 3'd1) begin
      if (kind == 3'd3) for (int c = 0; c < 512; c++) ram[row][c] = serReg[c];
      ptr = memAddr;
      rdMode = 1'b0;
      haveOut = 1'b0;
      started = 1'b1;
    end
  end
  // read transfer lands at the transfer/oe rise
  always @(posedge transferOutputEnableN) if (!rowStrobeN && kind == 3'd1) begin
    for (int c = 0; c < 512; c++) serReg[c] = ram[row][c];
    ptr = startCol;
    rdMode = 1'b1;
    haveOut = 1'b0;
    {started, dtRose, hasRd} = 3'b111;
    lastRd = row;
    if ($realtime - tSc < T_SCDT_NS) viol++;
  end
  always @(posedge rowStrobeN) begin
    if (kind == 3'd1 && !dtRose) viol++;
    tRas = $realtime;
  end
  // ==========================================
  // serial port
  always @(posedge serialShiftClock) begin
    if (!started) viol++;
    if ((kind == 3'd2 || kind == 3'd3) && (!rowStrobeN || $realtime - tRas < T_RASSC_NS))
      viol++;
    tSc = $realtime;
    if (rdMode) begin
      if (ctlOe) viol++;
      devData = serReg[ptr];
      haveOut = 1'b1;
    end else if (!serialPortEnableN) serReg[ptr] = sdIn;
    ptr = ptr + 9'h001; // wraps 511 to 0
  end
  always @(posedge ctlOe) if (!rowStrobeN && kind == 3'd2) viol++;
endmodule : vdc_vram_model

// >>> bench/test_dual_port_dram_transfer_and_serial_port.sv
`timescale 1ns/1ps
module test_dual_port_dram_transfer_and_serial_port;
  import vdc_pkg::*;
  logic              clk, nrst, hsel, hwrite, hreadyout, hresp, ctlOe, devOe;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              rasN, casN, weN, dtN, spEnN, shClk;
  logic [ROW_W-1:0]  memAddr;
  logic [SD_W-1:0]   ctlData, devData, floatVal, sdWire;
  int                num_errors, n_tests;
  // released pins show a changing pattern, not the last value
  assign sdWire = devOe ? devData : (ctlOe ? ctlData : floatVal);
  vdc_host #(.REF_INTERVAL(20)) dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rowStrobeN(rasN), .colStrobeN(casN),
    .writeStrobeN(weN), .transferOutputEnableN(dtN), .serialPortEnableN(spEnN),
    .serialShiftClock(shClk), .memAddr(memAddr), .serialDataIn(sdWire),
    .serialDataOut(ctlData), .serialDataOe(ctlOe));
  vdc_vram_model mdl (
    .rowStrobeN(rasN), .colStrobeN(casN), .writeStrobeN(weN),
    .transferOutputEnableN(dtN), .serialPortEnableN(spEnN), .serialShiftClock(shClk),
    .memAddr(memAddr), .sdIn(sdWire), .ctlOe(ctlOe), .devData(devData), .devOe(devOe));
  // ==========================================
  // helpers
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    cmp(r, exp);
  endtask : rdc
  task automatic cmd(input logic [3:0] op, input logic mask);
    logic [31:0] s;
    wr(OFF_CTRL, {27'h0, mask, op});
    repeat (2) @(posedge clk);
    s = 32'h1;
    for (int i = 0; i < 60 && s[ST_BUSY_BIT] !== 1'b0; i++) ahb(1'b0, OFF_STATUS, 32'h0, s);
    cmp({31'h0, s[ST_BUSY_BIT]}, 32'h0);
  endtask : cmd
  function automatic logic [31:0] st(input logic [8:0] p, input logic [2:0] f);
    return {7'h0, p, 12'h0, f, 1'b0}; // f = err, start, write mode
  endfunction : st
  function automatic logic [31:0] pat(input int r, input int c);
    return {28'h0, 4'(r ^ (c >> 2))};
  endfunction : pat
  // ==========================================
  // scenarios
  task automatic t_reset();
    rdc(OFF_STATUS, 32'h0);
    rdc(8'h20, 32'h0); // unmapped reads zero
    cmp({26'h0, rasN, casN, weN, dtN, spEnN, shClk}, 32'h3e);
    cmp({16'h0, hreadyout, hresp, ctlOe, ctlData, memAddr}, 32'h0000_8000);
    cmd(OP_SERIAL_READ, 1'b0); // refused before any start address
    rdc(OFF_STATUS, st(9'h0, 3'b100));
    wr(OFF_STATUS, 32'h8);
    rdc(OFF_STATUS, 32'h0);
  endtask : t_reset
  task automatic t_read();
    wr(OFF_ADDR, {7'h0, 9'h1fe, 7'h0, 9'h005});
    cmd(OP_READ_XFER, 1'b0);
    rdc(OFF_STATUS, st(9'h1fe, 3'b010));
    cmd(OP_SERIAL_READ, 1'b0);
    rdc(OFF_SDATA, pat(5, 9'h1fe));
    cmd(OP_SERIAL_READ, 1'b1); // masked, pointer still moves
    cmd(OP_SERIAL_READ, 1'b0);
    rdc(OFF_SDATA, pat(5, 0));
    rdc(OFF_STATUS, st(9'h001, 3'b010));
    wr(OFF_ADDR, {7'h0, 9'h000, 7'h0, 9'h105});
    cmd(OP_WRITE_XFER, 1'b0); // other half of the array: refused
    rdc(OFF_STATUS, st(9'h001, 3'b110));
    cmp({28'h0, mdl.ram[9'h105][0]}, pat(9'h105, 0));
    wr(OFF_STATUS, 32'h8);
  endtask : t_read
  task automatic t_write();
    wr(OFF_ADDR, {7'h0, 9'h1ff, 7'h0, 9'h000});
    cmd(OP_PSEUDO_XFER, 1'b0);
    rdc(OFF_STATUS, st(9'h1ff, 3'b011));
    wr(OFF_SDATA, 32'ha);
    cmd(OP_SERIAL_WRITE, 1'b0);
    wr(OFF_SDATA, 32'h5);
    cmd(OP_SERIAL_WRITE, 1'b1); // masked word at wrapped location
    wr(OFF_ADDR, {7'h0, 9'h003, 7'h0, 9'h006});
    cmd(OP_WRITE_XFER, 1'b0);
    rdc(OFF_STATUS, st(9'h003, 3'b011));
    cmp({28'h0, mdl.ram[6][9'h1ff]}, 32'ha);
    cmp({28'h0, mdl.ram[6][0]}, pat(5, 0));
    cmp({28'h0, mdl.ram[6][1]}, pat(5, 1));
  endtask : t_write
  task automatic t_refresh();
    int c;
    for (int k = 0; k < 3; k++) begin
      c = mdl.ctrCount;
      cmd(4'(int'(OP_RAS_REFRESH) + k), 1'b0);
      cmp(32'(mdl.ctrCount - c), (k == 0) ? 32'h0 : 32'h1);
    end
    wr(OFF_CTRL, 32'(OP_HIDDEN_REFRESH));
    wr(OFF_CTRL, 32'(OP_CTR_REFRESH)); // refused while busy
    repeat (20) @(posedge clk);
    rdc(OFF_STATUS, st(9'h003, 3'b111));
    wr(OFF_STATUS, 32'h8);
    c = mdl.ctrCount;
    wr(OFF_CONFIG, 32'h1);
    repeat (80) @(posedge clk);
    wr(OFF_CONFIG, 32'h0);
    repeat (20) @(posedge clk);
    cmp({31'h0, (mdl.ctrCount - c) >= 2}, 32'h1);
    cmp(32'(mdl.viol), 32'h0);
  endtask : t_refresh
  // ==========================================
  // clock, reset, sequence
  always @(posedge clk) floatVal <= ~floatVal;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(40000 * 100);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    floatVal = 4'h5;
    num_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_read();
    t_write();
    t_refresh();
    report_and_stop();
  end
endmodule : test_dual_port_dram_transfer_and_serial_port
